/* File: include/wdt_pkg.sv */
/*
 * Constants, types and register map of the watchdog timer with sleep wake.
 * Assumes a 25 MHz APB clock far faster than the 31 kHz low-rate oscillator.
 */
// Notes on behaviour
// - Counts edges of the 31 kHz low-rate oscillator, 1 ms base interval.
// - Active watchdog not cleared in time while awake requests a device reset.
// - Mode 11: always active, also asleep, enable bit ignored.
// - Mode 10: active awake, disabled asleep.
// - Mode 01: enable bit decides; sleep changes nothing.
// - Enable bit used only in mode 01, ignored in 1x and 00.
// - Mode 00, or mode 01 with enable low: disabled, held cleared.
// - Period code doubles prescale, 1:64 at 00001 to 1:8388608 at 10010.
// - Codes 10011 to 11111 give the minimum 1:32 prescale.
// - Period code resets to 01011, 1:65536, about two seconds.
// - Cleared by reset, clear instruction, sleep entry, wake, osc fail, off.
// - Sleep entry clears it; if enabled asleep it counts from zero.
// - Wake clears it; crystal clocks hold it clear until start-up ends.
// - Timeout asleep wakes the core, no reset, flags record the event.
// - Internal oscillator divider changes leave the count untouched.
// - Control bits 7 and 6 read as zero.
// - Sleep entry clears power-down flag and sets timeout flag (active low).
package wdt_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] OFF_CTRL      = 12'h000;
    localparam logic [11:0] OFF_STAT      = 12'h004;
    localparam logic [11:0] OFF_IRQ_STAT  = 12'h008;
    localparam logic [11:0] OFF_IRQ_MASK  = 12'h00C;

    // watchdog_control layout
    localparam int          CTRL_SWEN_BIT = 0;
    localparam int          CTRL_PS_LSB   = 1;
    localparam int          CTRL_PS_MSB   = 5;
    localparam int          CTRL_W        = 8;
    localparam logic [4:0]  PS_RESET      = 5'h0B;
    localparam logic [4:0]  PS_MAX_CODE   = 5'h12;
    localparam logic [4:0]  PS_MIN_CODE   = 5'h01;
    localparam logic        SWEN_RESET    = 1'h0;

    // Time base: 31 kHz oscillator, 1 ms base interval is 1:32
    localparam int          LFOSC_KHZ     = 31;
    localparam int          BASE_MS       = 1;
    localparam logic [4:0]  MIN_SHIFT     = 5'h05;
    localparam int          CNT_W         = 23;

    // Status register bits
    localparam int          STAT_TO_BIT   = 0;
    localparam int          STAT_PD_BIT   = 1;
    localparam int          STAT_SLP_BIT  = 2;
    localparam int          STAT_ACT_BIT  = 3;

    // Interrupt events
    localparam int          IRQ_W         = 2;
    localparam int          EV_WAKE_BIT   = 0;
    localparam int          EV_RESET_BIT  = 1;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_SW    = 2'b01,
        MODE_AWAKE = 2'b10,
        MODE_ON    = 2'b11
    } cfg_mode_e;

    typedef enum logic {
        ST_AWAKE  = 1'b0,
        ST_ASLEEP = 1'b1
    } power_state_e;

    typedef struct packed {
        logic timeout_flag_n;
        logic powerdown_flag_n;
    } sleep_flags_s;

endpackage

/* File: src/wdt_sleep_wake.sv */
/*
 * Watchdog timer with sleep wake-up, APB register slave and interrupt.
 * Assumes core strobes are one-cycle pulses on pclk and that the
 * low-rate oscillator input is asynchronous and much slower than pclk.
 */
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module wdt_sleep_wake
    import wdt_pkg::*;
#(
    parameter int PCLK_HZ = 25000000
)(
    // Clock, reset, enable
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    // Configuration word
    input  wire cfg_mode_e    wdt_cfg_mode,
    // Core side
    input  wire logic         clear_watchdog_insn,
    input  wire logic         sleep_req,
    input  wire logic         wake_src,
    input  wire logic         osc_fail,
    input  wire logic         clk_is_crystal,
    input  wire logic         osc_startup_timer,
    // Oscillator pin
    input  wire logic         low_freq_osc,
    // Results
    output logic              wdt_reset_req,
    output logic              wake_out,
    output logic              asleep,
    output sleep_flags_s      flags,
    output logic              irq
);

    initial begin
        if (PCLK_HZ < 4 * LFOSC_KHZ * 1000) begin
            $error("pclk too slow to sample the low-rate oscillator");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [4:0]        period_select;
    logic              sw_watchdog_on;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [CNT_W-1:0]  wdt_count;
    logic              osc_s1;
    logic              osc_s2;
    logic              osc_s3;
    power_state_e      state;

    logic              tick;
    logic              active;
    logic              sleep_go;
    logic              wake_go;
    logic              expire;
    logic              hold_clear;
    logic [4:0]        shift;
    logic [CNT_W-1:0]  last_count;
    logic              setup_ph;
    logic              access_done;
    logic              wr_done;
    logic              addr_ok;
    logic [31:0]       next_prdata;
    logic [IRQ_W-1:0]  events;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator synchroniser; s1 feeds s2 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else if (ce) begin
            osc_s1 <= low_freq_osc;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    // One count per oscillator rising edge, detected on pclk after the synchroniser
    assign tick = osc_s2 && !osc_s3;

    ////////////////////////////////////////////////////////////////////////
    // Operating mode
    always_comb begin
        case (wdt_cfg_mode)
            MODE_ON:    active = 1'b1;
            MODE_AWAKE: active = (state == ST_AWAKE);
            MODE_SW:    active = sw_watchdog_on;
            default:    active = 1'b0;
        endcase
    end

    // Reserved codes fall back to 1:32; others double per step
    always_comb begin
        if (period_select > PS_MAX_CODE) begin
            shift = MIN_SHIFT;
        end else begin
            shift = period_select + MIN_SHIFT;
        end
    end

    assign last_count = CNT_W'((24'h000001 << shift) - 24'h000001);
    assign sleep_go   = sleep_req && (state == ST_AWAKE);
    assign expire     = active && tick && (wdt_count == last_count);
    assign wake_go    = (state == ST_ASLEEP) && (wake_src || expire);

    // Divider changes of the internal oscillator are not a clear source
    assign hold_clear = !active || clear_watchdog_insn || sleep_go
                     || wake_go || osc_fail
                     || (clk_is_crystal && osc_startup_timer);

    ////////////////////////////////////////////////////////////////////////
    // Counter; one chain for prescaler and period so a clear restarts both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_count <= '0;
        end else if (ce) begin
            if (hold_clear && !expire) begin
                wdt_count <= '0;
            end else if (expire) begin
                wdt_count <= '0;
            end else if (tick) begin
                wdt_count <= wdt_count + CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_AWAKE;
        end else if (ce) begin
            case (state)
                ST_AWAKE: begin
                    if (sleep_go) begin
                        state <= ST_ASLEEP;
                    end
                end
                ST_ASLEEP: begin
                    if (wake_go) begin
                        state <= ST_AWAKE;
                    end
                end
                default: state <= ST_AWAKE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timeout and power-down flags, active low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};
        end else if (ce) begin
            if (expire) begin
                flags.timeout_flag_n <= 1'b0;
            end else if (sleep_go) begin
                flags.timeout_flag_n   <= 1'b1;
                flags.powerdown_flag_n <= 1'b0;
            end else if (clear_watchdog_insn) begin
                flags.timeout_flag_n   <= 1'b1;
                flags.powerdown_flag_n <= 1'b1;
            end
        end
    end

    // Reset request only when awake; a timeout asleep wakes instead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_reset_req <= 1'b0;
            wake_out      <= 1'b0;
            asleep        <= 1'b0;
        end else if (ce) begin
            wdt_reset_req <= expire && (state == ST_AWAKE);
            wake_out      <= wake_go;
            asleep        <= (state == ST_ASLEEP) && !wake_go
                          || sleep_go;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB: prdata and pready are set in the setup cycle, so every access
    // ends one cycle after setup; keeps all outputs on flip-flops
    assign setup_ph    = psel && !penable;
    assign access_done = psel && penable && pready;
    assign wr_done     = access_done && pwrite && !pslverr;
    assign addr_ok     = (paddr == OFF_CTRL) || (paddr == OFF_STAT)
                      || (paddr == OFF_IRQ_STAT) || (paddr == OFF_IRQ_MASK);

    always_comb begin
        next_prdata = '0;
        if (paddr == OFF_CTRL) begin
            // Bits 7 and 6 stay zero
            next_prdata[CTRL_PS_MSB:CTRL_PS_LSB] = period_select;
            next_prdata[CTRL_SWEN_BIT]           = sw_watchdog_on;
        end else if (paddr == OFF_STAT) begin
            next_prdata[STAT_TO_BIT]  = flags.timeout_flag_n;
            next_prdata[STAT_PD_BIT]  = flags.powerdown_flag_n;
            next_prdata[STAT_SLP_BIT] = (state == ST_ASLEEP);
            next_prdata[STAT_ACT_BIT] = active;
        end else if (paddr == OFF_IRQ_STAT) begin
            next_prdata[IRQ_W-1:0] = irq_stat;
        end else if (paddr == OFF_IRQ_MASK) begin
            next_prdata[IRQ_W-1:0] = irq_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (setup_ph) begin
                prdata  <= pwrite ? 32'h00000000 : next_prdata;
                pready  <= 1'b1;
                pslverr <= !addr_ok;
            end else if (access_done) begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // Control register; the period reset value is a two-second timeout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_select  <= PS_RESET;
            sw_watchdog_on <= SWEN_RESET;
        end else if (ce && wr_done && paddr == OFF_CTRL) begin
            period_select  <= pwdata[CTRL_PS_MSB:CTRL_PS_LSB];
            sw_watchdog_on <= pwdata[CTRL_SWEN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky events, write one to clear, a new event wins
    always_comb begin
        events               = '0;
        events[EV_WAKE_BIT]  = expire && (state == ST_ASLEEP);
        events[EV_RESET_BIT] = expire && (state == ST_AWAKE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else if (ce) begin
            if (wr_done && paddr == OFF_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | events;
            end else begin
                irq_stat <= irq_stat | events;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (ce && wr_done && paddr == OFF_IRQ_MASK) begin
            irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_always_on;
        wdt_cfg_mode == MODE_ON |-> active;
    endproperty
    a_always_on: assert property (p_always_on)
        else $error("mode 11 not active");

    property p_off_in_sleep;
        (wdt_cfg_mode == MODE_AWAKE) |-> (active == (state == ST_AWAKE));
    endproperty
    a_off_in_sleep: assert property (p_off_in_sleep)
        else $error("mode 10 activity wrong");

    property p_sw_ctrl;
        (wdt_cfg_mode == MODE_SW) |-> (active == sw_watchdog_on);
    endproperty
    a_sw_ctrl: assert property (p_sw_ctrl)
        else $error("mode 01 does not follow enable bit");

    property p_disabled_clear;
        (ce && !active) |=> (wdt_count == '0);
    endproperty
    a_disabled_clear: assert property (p_disabled_clear)
        else $error("disabled watchdog not held clear");

    property p_reserved_min;
        (period_select > PS_MAX_CODE) |-> (last_count == CNT_W'(31));
    endproperty
    a_reserved_min: assert property (p_reserved_min)
        else $error("reserved code not minimum interval");

    property p_period;
        expire |-> (wdt_count == last_count) && (shift >= MIN_SHIFT + 5'h01
                    || period_select > PS_MAX_CODE
                    || period_select == 5'h00);
    endproperty
    a_period: assert property (p_period)
        else $error("timeout before selected period");

    property p_clear_insn;
        (ce && clear_watchdog_insn) |=> (wdt_count == '0);
    endproperty
    a_clear_insn: assert property (p_clear_insn)
        else $error("clear instruction did not clear");

    property p_ost_hold;
        (ce && clk_is_crystal && osc_startup_timer) |=> (wdt_count == '0);
    endproperty
    a_ost_hold: assert property (p_ost_hold)
        else $error("count moved during start-up timer");

    property p_sleep_flags;
        (ce && sleep_go) |=> !flags.powerdown_flag_n && flags.timeout_flag_n
                             && state == ST_ASLEEP && wdt_count == '0;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags)
        else $error("sleep entry flags wrong");

    property p_sleep_timeout;
        (ce && expire && state == ST_ASLEEP)
            |=> wake_out && !wdt_reset_req && !flags.timeout_flag_n
                && state == ST_AWAKE;
    endproperty
    a_sleep_timeout: assert property (p_sleep_timeout)
        else $error("sleep timeout did not wake cleanly");

    property p_awake_timeout;
        (ce && expire && state == ST_AWAKE)
            |=> wdt_reset_req && !flags.timeout_flag_n ##1 !wdt_reset_req;
    endproperty
    a_awake_timeout: assert property (p_awake_timeout)
        else $error("awake timeout did not request reset");

    property p_ctrl_high_zero;
        (pready && !pwrite && paddr == OFF_CTRL) |-> prdata[7:6] == 2'b00;
    endproperty
    a_ctrl_high_zero: assert property (p_ctrl_high_zero)
        else $error("control bits 7:6 not zero");

    c_reset_req: cover property (ce && expire && state == ST_AWAKE);
    c_sleep_wake: cover property (sleep_go ##[1:1000] wake_out);
    c_irq: cover property ($rose(irq));

endmodule

/* File: tb/core_model.sv */
/*
 * Model of the processor core and the low-rate oscillator pin.
 * Assumes the watchdog samples its strobes on the rising edge of pclk.
 */
`timescale 1ns/10ps
module core_model #(
    parameter int OSC_P = 10
)(
    // Clock
    input  wire logic pclk,
    // Core strobes
    output logic      clear_watchdog_insn,
    output logic      sleep_req,
    output logic      wake_src,
    // Oscillator pin
    output logic      low_freq_osc
);
    int phase = 0;

    initial begin
        clear_watchdog_insn = 1'b0;
        sleep_req = 1'b0;
        wake_src = 1'b0;
        low_freq_osc = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shortened oscillator so that long periods stay simulable
    always @(posedge pclk) begin
        phase <= (phase == OSC_P - 1) ? 0 : phase + 1;
        low_freq_osc <= (phase < OSC_P / 2);
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobes launch mid-period, away from a counted oscillator edge
    task automatic strobe(input int k);
        while (phase != 6) @(posedge pclk);
        case (k)
            0: clear_watchdog_insn <= 1'b1;
            1: sleep_req <= 1'b1;
            2: wake_src <= 1'b1;
            default: ;
        endcase
        @(posedge pclk);
        clear_watchdog_insn <= 1'b0;
        sleep_req <= 1'b0;
        wake_src <= 1'b0;
    endtask
endmodule

/* File: tb/watchdog_timer_with_sleep_wake_test.sv */
/*
 * Self-checking bench for the watchdog timer with sleep wake.
 * Assumes the core model drives strobes and a shortened oscillator.
 */
`timescale 1ns/10ps
module watchdog_timer_with_sleep_wake_test;
    import wdt_pkg::*;
    localparam int P = 10;
    typedef struct packed {
        logic [1:0]  kind;
        logic [32:0] val;
    } note_s;

    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         ce = 1'b1;
    logic [31:0]  rnd;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    cfg_mode_e    mode = MODE_OFF;
    logic         osc_fail = 1'b0;
    logic         clk_is_crystal = 1'b0;
    logic         osc_startup_timer = 1'b0;
    logic         clear_watchdog_insn, sleep_req, wake_src, low_freq_osc;
    logic         wdt_reset_req, wake_out, asleep, irq;
    sleep_flags_s flags;
    note_s        q[$];
    int           error_cnt = 0;
    int           n_tests = 0;
    int           cyc = 0;
    int           t0;
    int           tm[6] = '{1, 2, 3, 1, 1, 2};
    int           te[6] = '{1, 0, 0, 1, 1, 0};
    int           tc[6] = '{19, 1, 0, 2, 0, 3};

    always #20 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    wdt_sleep_wake u_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdt_cfg_mode(mode),
        .clear_watchdog_insn(clear_watchdog_insn), .sleep_req(sleep_req),
        .wake_src(wake_src), .osc_fail(osc_fail),
        .clk_is_crystal(clk_is_crystal),
        .osc_startup_timer(osc_startup_timer),
        .low_freq_osc(low_freq_osc), .wdt_reset_req(wdt_reset_req),
        .wake_out(wake_out), .asleep(asleep), .flags(flags), .irq(irq)
    );

    core_model #(.OSC_P(P)) u_core (
        .pclk(pclk), .clear_watchdog_insn(clear_watchdog_insn),
        .sleep_req(sleep_req), .wake_src(wake_src),
        .low_freq_osc(low_freq_osc)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [32:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic push(input logic [1:0] k, input logic [32:0] v);
        q.push_back(note_s'({k, v}));
    endtask

    task automatic take(input logic [1:0] k, input logic [32:0] v);
        note_s n;
        if (q.size() == 0) begin
            chk("unexpected_result", 33'(k), 33'h3);
        end else begin
            n = q.pop_front();
            chk("result_kind", 33'(k), 33'(n.kind));
            chk("result_value", v, n.val);
        end
    endtask

    // Every read, reset request and wake appearing at the ports is matched against the queue
    always @(posedge pclk) begin
        if (presetn) begin
            if (psel && penable && pready === 1'b1 && !pwrite)
                take(2'd0, {pslverr, prdata});
            if (wdt_reset_req === 1'b1)
                take(2'd1, {30'h0, asleep, flags});
            if (wake_out === 1'b1)
                take(2'd2, {30'h0, asleep, flags});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Waits as long as the slave needs; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns psel in this step
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        push(2'd0, exp);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic drain(input int n);
        int i;
        i = 0;
        while (q.size() != 0 && i < n) begin
            @(posedge pclk);
            i++;
        end
        chk("pending_results", 33'(q.size()), 33'h0);
        q.delete();
    endtask

    // Event must come in the last half period, not one edge early
    task automatic expect_ev(input logic [1:0] k, input logic [32:0] v,
                             input int n);
        while (cyc < t0 + n * P - 5) @(posedge pclk);
        push(k, v);
        drain(P + 10);
    endtask

    task automatic cfg(input int m, input int en, input int code);
        apb(1'b1, OFF_CTRL, {26'h0, code[4:0], en[0]});
        mode <= cfg_mode_e'(m[1:0]);
        rd(OFF_CTRL, {27'h0, code[4:0], en[0]});
    endtask

    function automatic int edges(input int code);
        return (code >= 1 && code <= 18) ? (1 << (code + 5)) : 32;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(70));
        tc[4] = $urandom_range(31, 19);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFF_CTRL, 33'h16);
        rd(OFF_STAT, 33'h3);
        rd(OFF_IRQ_STAT, 33'h0);
        rd(12'h010, 33'h1_0000_0000);
        apb(1'b1, OFF_CTRL, 32'hFF);
        rd(OFF_CTRL, 33'h3F);
        apb(1'b1, OFF_IRQ_MASK, 32'h2);
        cfg(0, 1, 19);
        repeat (64 * P) @(posedge pclk);
        cfg(1, 0, 19);
        repeat (64 * P) @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            cfg(tm[i], te[i], tc[i]);
            u_core.strobe(0);
            repeat (edges(tc[i]) * P / 2) @(posedge pclk);
            u_core.strobe(0);
            t0 = cyc;
            expect_ev(2'd1, 33'h1, edges(tc[i]));
            mode <= MODE_OFF;
        end
        repeat (2) @(posedge pclk);
        chk("irq", 33'(irq), 33'h1);
        rd(OFF_IRQ_STAT, 33'h2);
        apb(1'b1, OFF_IRQ_STAT, 32'h2);
        rd(OFF_IRQ_STAT, 33'h0);
        chk("irq", 33'(irq), 33'h0);
        for (int h = 0; h < 2; h++) begin
            cfg(1, 1, 19);
            rnd = $urandom;
            osc_fail <= (h == 0);
            clk_is_crystal <= (h == 1) || rnd[0];
            osc_startup_timer <= (h == 1) || rnd[1];
            u_core.strobe(0);
            repeat (64 * P) @(posedge pclk);
            u_core.strobe(3);
            osc_fail <= 1'b0;
            osc_startup_timer <= 1'b0;
            t0 = cyc;
            expect_ev(2'd1, 33'h1, 32);
            mode <= MODE_OFF;
        end
        // A frozen clock enable delays the timeout by the freeze length
        cfg(3, 0, 19);
        u_core.strobe(0);
        t0 = cyc + 100;
        ce <= 1'b0;
        repeat (100) @(posedge pclk);
        ce <= 1'b1;
        expect_ev(2'd1, 33'h1, 32);
        mode <= MODE_OFF;
        cfg(3, 0, 19);
        u_core.strobe(1);
        t0 = cyc;
        rd(OFF_STAT, 33'hD);
        expect_ev(2'd2, 33'h0, 32);
        mode <= MODE_OFF;
        cfg(2, 0, 19);
        u_core.strobe(1);
        rd(OFF_STAT, 33'h5);
        repeat (64 * P) @(posedge pclk);
        push(2'd2, 33'h2);
        u_core.strobe(2);
        mode <= MODE_OFF;
        drain(P);
        rd(OFF_IRQ_STAT, 33'h3);
        apb(1'b1, OFF_IRQ_STAT, 32'h2);
        rd(OFF_IRQ_STAT, 33'h1);
        chk("irq", 33'(irq), 33'h0);
        apb(1'b1, OFF_IRQ_MASK, 32'h3);
        repeat (2) @(posedge pclk);
        chk("irq", 33'(irq), 33'h1);
        results();
    end

    // Whole run is near 13000 cycles; a hang is cut off well after that
    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        results();
    end
endmodule
